// >>> hdl/pca_pkg.sv
// ==========================================================================
// shared constants for the protection channel alarm logic
package pca_pkg;

    // ======================================================================
    // sizes
    localparam int NUM_CMP   = 8;              // comparator outputs per channel
    localparam int RTD_IN    = 4;              // temperature inputs per group
    localparam int CNT_W     = 25;             // persistence counter width
    localparam int MIN_GOOD  = 2;              // fewest good inputs allowed
    localparam int MAX_BAD   = 2;              // bad inputs that raise alarm

    // ======================================================================
    // comparator kinds, one bit per comparator
    localparam logic [NUM_CMP-1:0] DE_TRIP_MASK    = 8'h3f; // deenergize to trip
    localparam logic [NUM_CMP-1:0] MANUAL_MASK     = 8'h3f; // manual trip fitted
    localparam logic [NUM_CMP-1:0] ALARM_ONLY_MASK = 8'h20; // alarm-only outputs
    localparam logic [NUM_CMP-1:0] INTERLOCK_MASK  = 8'h1c; // control interlocks
    localparam logic [NUM_CMP-1:0] SPRAY_MASK      = 8'h40; // spray hi-hi pressure
    localparam logic [NUM_CMP-1:0] PERMISSIVE_MASK = 8'h80; // impulse pressure hi

    // ======================================================================
    // layout of the synchronised pin vector
    localparam int SY_MAN  = 0;
    localparam int SY_HOLD = NUM_CMP;
    localparam int SY_IND  = 2 * NUM_CMP;
    localparam int SY_FBL  = 3 * NUM_CMP;
    localparam int SY_FBC  = 4 * NUM_CMP;
    localparam int SY_OOS  = 5 * NUM_CMP;
    localparam int SY_DELTA_AVG_TEMP_CHANNEL = 5 * NUM_CMP + 1;
    localparam int SY_CPS  = 5 * NUM_CMP + 2;   // two bits
    localparam int SY_NPS  = 5 * NUM_CMP + 4;   // two bits
    localparam int PIN_W   = 5 * NUM_CMP + 6;

    // ======================================================================
    // timing
    localparam int CLK_HZ          = 25_000_000;
    localparam int PERSIST_TIME_MS = 1000;
    localparam int OOS_CONFIRM_MS  = 100;
    localparam int PERSIST_CYC     = (CLK_HZ / 1000) * PERSIST_TIME_MS;
    localparam int OOS_CONFIRM_CYC = (CLK_HZ / 1000) * OOS_CONFIRM_MS;

    // ======================================================================
    // out-of-service confirmation states, gray along the path
    typedef enum logic [1:0] {
        PCA_OOS_IDLE    = 2'h0,
        PCA_OOS_CONFIRM = 2'h1,
        PCA_OOS_EST     = 2'h3
    } pca_oos_t;

endpackage

// >>> hdl/pca_channel_alarm.sv
`timescale 1ns/100ps
`default_nettype none

module pca_channel_alarm #(
    parameter int PERSIST_CYCLES = pca_pkg::PERSIST_CYC,
    parameter int OOS_CYCLES     = pca_pkg::OOS_CONFIRM_CYC
) (
    input  wire logic                        sys_clk_i,
    input  wire logic                        reset_n_i,
    input  wire logic                        ce_i,
    input  wire logic [pca_pkg::NUM_CMP-1:0] cmp_demand_i,
    input  wire logic [pca_pkg::NUM_CMP-1:0] manual_trip_i,
    input  wire logic [pca_pkg::NUM_CMP-1:0] bypass_hold_i,
    input  wire logic [pca_pkg::NUM_CMP-1:0] bypass_ind_i,
    input  wire logic [pca_pkg::NUM_CMP-1:0] fb_level_i,
    input  wire logic [pca_pkg::NUM_CMP-1:0] fb_current_i,
    input  wire logic                        out_of_service_i,
    input  wire logic                        delta_avg_temp_channel_oos_i,
    input  wire logic [1:0]                  crit_supply_ok_i,
    input  wire logic [1:0]                  noncrit_supply_ok_i,
    input  wire logic                        crit_fail_i,
    input  wire logic                        minor_fail_i,
    input  wire logic                        deviation_check_group_dev_i,
    input  wire logic [pca_pkg::RTD_IN-1:0]  deviation_check_group_bad_i,
    input  wire logic [pca_pkg::RTD_IN-1:0]  good_input_group_a_i,
    input  wire logic [pca_pkg::RTD_IN-1:0]  good_input_group_b_i,
    output logic      [pca_pkg::NUM_CMP-1:0] trip_drive_o,
    output logic      [pca_pkg::NUM_CMP-1:0] cmp_status_o,
    output logic      [pca_pkg::NUM_CMP-1:0] fb_fault_o,
    output logic                             failure_alarm_n_o,
    output logic                             trouble_alarm_n_o,
    output logic                             bypass_alarm_o,
    output logic                             inoperable_o,
    output logic                             rtd_alarm_o,
    output logic                             maint_enable_o,
    output logic                             oos_alarm_o
);
    import pca_pkg::*;

    // ======================================================================
    // overview of the data path
    //
    // pin-side inputs (manual trip, bypass contacts, feedback,
    // out-of-service contacts, supply monitors) pass the two-flop
    // synchroniser in sync1 and sync2 before anything reads them.
    // comparator demands and health flags come from logic on this
    // clock and are read directly.
    //
    // the trip drive is registered once: a demand reaches the
    // voting logic one edge later, a pin three edges later.
    //
    // feedback is compared with the command delayed two edges,
    // matching the synchroniser lag, so a healthy loop never
    // shows a fault while it switches.
    //
    // persistence counters saturate at the limit instead of
    // wrapping, so a mismatch lasting hours keeps its alarm.
    //
    // clock enable low freezes every flop, counters included, so
    // the one-second checks count enabled cycles, not wall time.
    //
    // alarms:
    //   failure - demand not met for the limit, critical fault,
    //             both critical supplies lost; low means alarm
    //   trouble - trip without demand for the limit, feedback
    //             fault, minor fault, one critical or any
    //             non-critical supply lost; low means alarm
    //   bypass  - bypass indication contact closed on the spray or permissive output
    //   rtd     - temperature input checks, masked while the
    //             delta/avg channel is out of service
    //   oos     - out-of-service contact held through the
    //             confirm window

    // ======================================================================
    // state
    // all state is one packed struct: next_r is filled by the
    // combinational block and r registers it, so every flop
    // shares one reset and one enable
    typedef struct packed {
        logic [PIN_W-1:0]                sync1;
        logic [PIN_W-1:0]                sync2;
        logic [NUM_CMP-1:0][CNT_W-1:0]   fail_cnt;
        logic [NUM_CMP-1:0][CNT_W-1:0]   spur_cnt;
        logic [CNT_W-1:0]                oos_cnt;
        pca_oos_t                        oos_state;
        logic [NUM_CMP-1:0]              drive;
        logic [NUM_CMP-1:0]              drive_d1;
        logic [NUM_CMP-1:0]              drive_d2;
        logic [NUM_CMP-1:0]              status;
        logic [NUM_CMP-1:0]              fb_fault;
        logic                            failure_n;
        logic                            trouble_n;
        logic                            bypass_alarm;
        logic                            inoperable;
        logic                            rtd_alarm;
        logic                            maint_en;
        logic                            oos_alarm;
    } pca_state_t;


    // ======================================================================
    // derived constants
    // the counter width must hold the largest limit; a smaller
    // limit in simulation only shortens the runs
    localparam logic [CNT_W-1:0] PERSIST_LIM = CNT_W'(PERSIST_CYCLES);
    localparam logic [CNT_W-1:0] OOS_LIM     = CNT_W'(OOS_CYCLES);
    localparam logic [NUM_CMP-1:0] EXCLUDED  = ALARM_ONLY_MASK | INTERLOCK_MASK;
    localparam logic [NUM_CMP-1:0] BYPASSABLE = SPRAY_MASK | PERMISSIVE_MASK;
    localparam logic [CNT_W-1:0] CNT_ONE     = CNT_W'(1);
    localparam logic [2:0]       GOOD_MIN    = 3'(MIN_GOOD);
    localparam logic [2:0]       BAD_MAX     = 3'(MAX_BAD);

    pca_state_t r;
    pca_state_t next_r;

    // ======================================================================
    // helpers
    // population count for the temperature groups; four inputs
    // are few enough for a plain loop
    function automatic logic [2:0] count_ones(input logic [RTD_IN-1:0] v);
        logic [2:0] n;
        n = 3'h0;
        for (int k = 0; k < RTD_IN; k++) begin
            n = n + {2'h0, v[k]};
        end
        return n;
    endfunction


    // ======================================================================
    // pin vector
    // packed in the order of the package offsets; changing one
    // without the other reads the wrong contact
    logic [PIN_W-1:0] pins;
    assign pins = {noncrit_supply_ok_i, crit_supply_ok_i,
                   delta_avg_temp_channel_oos_i, out_of_service_i,
                   fb_current_i, fb_level_i, bypass_ind_i,
                   bypass_hold_i, manual_trip_i};

    // ======================================================================
    // next-state logic
    always_comb begin
        logic hold;
        logic want;
        logic trip_cmd;
        logic fbl;
        logic fbc;
        logic tripped;
        logic fail_cond;
        logic spur_cond;
        logic fail_any;
        logic spur_any;
        logic fb_any;
        logic byp_any;
        logic rtd_cond;
        logic oos_in;
        hold      = 1'b0;
        want      = 1'b0;
        trip_cmd  = 1'b0;
        fbl       = 1'b0;
        fbc       = 1'b0;
        tripped   = 1'b0;
        fail_cond = 1'b0;
        spur_cond = 1'b0;
        fail_any  = 1'b0;
        spur_any  = 1'b0;
        fb_any    = 1'b0;
        byp_any   = 1'b0;
        rtd_cond  = 1'b0;
        oos_in    = 1'b0;
        next_r    = r;

        // pins cross in through two flops; only sync2 is read below
        next_r.sync1 = pins;
        next_r.sync2 = r.sync1;

        // delayed command lines up with the feedback's two-flop lag
        next_r.drive_d1 = r.drive;
        next_r.drive_d2 = r.drive_d1;

        // per comparator: hold, demand, drive, status, fault, counts.
        // hold is forced low off the spray and permissive outputs,
        // so a stray contact cannot mask a real trip
        for (int i = 0; i < NUM_CMP; i++) begin
            hold = BYPASSABLE[i] & r.sync2[SY_HOLD + i];
            want = cmp_demand_i[i] | (MANUAL_MASK[i] & r.sync2[SY_MAN + i]);
            // bypass wins over a trip: the hold contact is physical anyway
            trip_cmd = want & ~hold;
            next_r.drive[i] = DE_TRIP_MASK[i] ? ~trip_cmd : trip_cmd;

            // sensed state beyond the manual switch
            fbl = r.sync2[SY_FBL + i];
            fbc = r.sync2[SY_FBC + i];
            tripped = DE_TRIP_MASK[i] ? ~fbl : fbl;
            next_r.status[i] = tripped;

            // open and short only mean something on energize-to-trip
            // outputs; the others read back through status alone
            // open: on but no current; short: off but current; or level mismatch
            next_r.fb_fault[i] = ~DE_TRIP_MASK[i] &
                                 ((r.drive_d2[i] & ~fbc) |
                                  (~r.drive_d2[i] & fbc) |
                                  (r.drive_d2[i] ^ fbl));
            fb_any = fb_any | r.fb_fault[i];

            // persistence; bypassed and excluded comparators never count
            fail_cond = ~EXCLUDED[i] & ~hold & want & ~tripped;
            spur_cond = ~EXCLUDED[i] & ~hold & tripped & ~want;
            if (!fail_cond) begin
                next_r.fail_cnt[i] = '0;
            end else if (r.fail_cnt[i] != PERSIST_LIM) begin
                next_r.fail_cnt[i] = r.fail_cnt[i] + CNT_ONE;
            end
            if (!spur_cond) begin
                next_r.spur_cnt[i] = '0;
            end else if (r.spur_cnt[i] != PERSIST_LIM) begin
                next_r.spur_cnt[i] = r.spur_cnt[i] + CNT_ONE;
            end
            fail_any = fail_any | (r.fail_cnt[i] == PERSIST_LIM);
            spur_any = spur_any | (r.spur_cnt[i] == PERSIST_LIM);

            byp_any = byp_any | (BYPASSABLE[i] & r.sync2[SY_IND + i]);
        end


        // both critical supplies gone is a failure, one gone is
        // trouble; the non-critical pair only raises trouble.
        // these two rest high so a broken wire reads as alarm
        // set-level annunciator drives, low means alarm for these two
        next_r.failure_n = ~(fail_any | crit_fail_i |
                             (r.sync2[SY_CPS +: 2] == 2'h0));
        next_r.trouble_n = ~(spur_any | fb_any | minor_fail_i |
                             (r.sync2[SY_CPS] ^ r.sync2[SY_CPS + 1]) |
                             (r.sync2[SY_NPS +: 2] != 2'h3));
        next_r.bypass_alarm = byp_any;
        // out of service does not count: the trip outputs keep working
        next_r.inoperable   = byp_any;

        // good groups alarm below two good inputs each; the
        // deviation group alarms on a deviation or two bad inputs
        // temperature sensor failure, masked while that channel is out
        rtd_cond = deviation_check_group_dev_i |
                   (count_ones(deviation_check_group_bad_i) >= BAD_MAX) |
                   (count_ones(good_input_group_a_i) < GOOD_MIN) |
                   (count_ones(good_input_group_b_i) < GOOD_MIN);
        next_r.rtd_alarm = rtd_cond & ~r.sync2[SY_DELTA_AVG_TEMP_CHANNEL];


        // the confirm window rejects bounce and brief handling of
        // the switch; the alarm drops at once when it opens
        // out of service: maintenance follows the contact at once, but
        // the reflash alarm waits until the contact has held steady
        oos_in = r.sync2[SY_OOS];
        next_r.maint_en = oos_in;
        case (r.oos_state)
            PCA_OOS_IDLE: begin
                next_r.oos_cnt = '0;
                if (oos_in) begin
                    next_r.oos_state = PCA_OOS_CONFIRM;
                end
            end
            PCA_OOS_CONFIRM: begin
                if (!oos_in) begin
                    next_r.oos_state = PCA_OOS_IDLE;
                end else if (r.oos_cnt == OOS_LIM) begin
                    next_r.oos_state = PCA_OOS_EST;
                end else begin
                    next_r.oos_cnt = r.oos_cnt + CNT_ONE;
                end
            end
            PCA_OOS_EST: begin
                if (!oos_in) begin
                    next_r.oos_state = PCA_OOS_IDLE;
                end
            end
            default: begin
                next_r.oos_state = PCA_OOS_IDLE;
            end
        endcase
        // trip outputs are untouched by oos, so the set stays operable
        next_r.oos_alarm = (next_r.oos_state == PCA_OOS_EST);
    end

    // ======================================================================
    // state register; reset leaves outputs non-tripped and alarms clear
    // limitation: reset drops any trip at once; trips come back
    // within three edges of release, once the synchronisers refill
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r           <= '0;
            r.oos_state <= PCA_OOS_IDLE;
            r.drive     <= DE_TRIP_MASK;
            r.drive_d1  <= DE_TRIP_MASK;
            r.drive_d2  <= DE_TRIP_MASK;
            r.failure_n <= 1'b1;
            r.trouble_n <= 1'b1;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    // ======================================================================
    // outputs straight from flops
    // no logic between flop and pin, so nothing glitches toward
    // the voting logic or the annunciator
    assign trip_drive_o      = r.drive;
    assign cmp_status_o      = r.status;
    assign fb_fault_o        = r.fb_fault;
    assign failure_alarm_n_o = r.failure_n;
    assign trouble_alarm_n_o = r.trouble_n;
    assign bypass_alarm_o    = r.bypass_alarm;
    assign inoperable_o      = r.inoperable;
    assign rtd_alarm_o       = r.rtd_alarm;
    assign maint_enable_o    = r.maint_en;
    assign oos_alarm_o       = r.oos_alarm;

endmodule

`default_nettype wire

// >>> sim/pca_channel_alarm_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ====================
// port-level checks for the channel alarm block
module pca_channel_alarm_checker #(
    parameter int PERSIST_CYCLES = 20
) (
    input wire logic                        sys_clk_i,
    input wire logic                        reset_n_i,
    input wire logic                        ce_i,
    input wire logic                        crit_fail_i,
    input wire logic                        delta_avg_temp_channel_oos_i,
    input wire logic [pca_pkg::NUM_CMP-1:0] cmp_demand_i,
    input wire logic [pca_pkg::NUM_CMP-1:0] manual_trip_i,
    input wire logic [pca_pkg::NUM_CMP-1:0] bypass_hold_i,
    input wire logic [pca_pkg::NUM_CMP-1:0] bypass_ind_i,
    input wire logic [pca_pkg::NUM_CMP-1:0] trip_drive_o,
    input wire logic [pca_pkg::NUM_CMP-1:0] cmp_status_o,
    input wire logic                        failure_alarm_n_o,
    input wire logic                        trouble_alarm_n_o,
    input wire logic                        bypass_alarm_o,
    input wire logic                        inoperable_o,
    input wire logic                        rtd_alarm_o,
    input wire logic                        maint_enable_o,
    input wire logic                        oos_alarm_o
);
    import pca_pkg::*;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    // ====================
    // mismatch run lengths; frozen with ce so they track the design's own
    int n_fail;
    int n_spur;
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            n_fail <= 0;
            n_spur <= 0;
        end else if (ce_i) begin
            n_fail <= (cmp_demand_i[0] && !cmp_status_o[0]) ? n_fail + 1 : 0;
            n_spur <= (!cmp_demand_i[1] && !manual_trip_i[1] && cmp_status_o[1]) ? n_spur + 1 : 0;
        end
    end
    // ====================
    // pin inputs need three edges through the sync chain
    sequence s_man_held; (ce_i && manual_trip_i[0]) [*3]; endsequence
    sequence s_byp_held; (ce_i && bypass_hold_i[6]) [*3]; endsequence
    sequence s_ind_held; (ce_i && |bypass_ind_i[7:6]) [*3]; endsequence
    sequence s_delta_avg_temp_channel_held; (ce_i && delta_avg_temp_channel_oos_i) [*3]; endsequence
    property p_de_trip;
        ce_i && |(cmp_demand_i & DE_TRIP_MASK) |=>
            (trip_drive_o & $past(cmp_demand_i) & DE_TRIP_MASK) == 8'h00;
    endproperty
    property p_manual; s_man_held |=> !trip_drive_o[0]; endproperty
    property p_spray; s_byp_held |=> !trip_drive_o[6]; endproperty
    property p_fail; n_fail > PERSIST_CYCLES + 4 |-> !failure_alarm_n_o; endproperty
    property p_spur; n_spur > PERSIST_CYCLES + 4 |-> !trouble_alarm_n_o; endproperty
    property p_crit; ce_i && crit_fail_i |=> !failure_alarm_n_o; endproperty
    property p_bypass; s_ind_held |=> bypass_alarm_o && inoperable_o; endproperty
    property p_rtd_off; s_delta_avg_temp_channel_held |=> !rtd_alarm_o; endproperty
    property p_oos; $rose(oos_alarm_o) |-> maint_enable_o && $past(maint_enable_o, 8); endproperty
    a_de_trip: assert property (p_de_trip) else $error("demand did not trip");
    a_manual: assert property (p_manual) else $error("manual trip ignored");
    a_spray: assert property (p_spray) else $error("bypass did not hold");
    a_fail: assert property (p_fail) else $error("no failure alarm");
    a_spur: assert property (p_spur) else $error("no trouble alarm");
    a_crit: assert property (p_crit) else $error("critical fault missed");
    a_bypass: assert property (p_bypass) else $error("bypass not shown");
    a_rtd_off: assert property (p_rtd_off) else $error("rtd not suppressed");
    a_oos: assert property (p_oos) else $error("oos alarm too early");
endmodule
`default_nettype wire

// >>> sim/pca_field_model.sv
`timescale 1ns/100ps
`default_nettype none
// ====================
// field side: loads with feedback, bypass and out-of-service switches
module pca_field_model (
    input  wire logic [pca_pkg::NUM_CMP-1:0] trip_drive_i,
    input  wire logic [pca_pkg::NUM_CMP-1:0] break_i,
    input  wire logic [pca_pkg::NUM_CMP-1:0] byp_sw_i,
    input  wire logic                        oos_sw_i,
    output logic      [pca_pkg::NUM_CMP-1:0] fb_level_o,
    output logic      [pca_pkg::NUM_CMP-1:0] fb_current_o,
    output logic      [pca_pkg::NUM_CMP-1:0] bypass_hold_o,
    output logic      [pca_pkg::NUM_CMP-1:0] bypass_ind_o,
    output logic                             oos_contact_o,
    output logic                             oos_direct_o
);
    import pca_pkg::*;
    // a break bit models an open or shorted load, so feedback disagrees
    assign fb_level_o   = trip_drive_i ^ break_i;
    assign fb_current_o = trip_drive_i ^ break_i;
    // one lever closes both contacts of a switch together
    assign bypass_hold_o = byp_sw_i;
    assign bypass_ind_o  = byp_sw_i;
    assign oos_contact_o = oos_sw_i;
    assign oos_direct_o  = oos_sw_i;
endmodule
`default_nettype wire

// >>> sim/pca_channel_alarm_tb.sv
`timescale 1ns/100ps
`default_nettype none
module pca_channel_alarm_tb;
    import pca_pkg::*;
    localparam int PC    = 20;
    localparam int OC    = 10;
    localparam int LIMIT = 5000;
    // ====================
    // signals carry the port names so the instance connects by name
    logic               sys_clk_i = 1'b0, reset_n_i = 1'b0, ce_i = 1'b1, oos_sw = 1'b0;
    logic               crit_fail_i = 1'b0, minor_fail_i = 1'b0;
    logic               deviation_check_group_dev_i = 1'b0, delta_avg_temp_channel_oos_i = 1'b0;
    logic [1:0]         crit_supply_ok_i = 2'h3, noncrit_supply_ok_i = 2'h3;
    logic [RTD_IN-1:0]  deviation_check_group_bad_i = 4'h0;
    logic [RTD_IN-1:0]  good_input_group_a_i = 4'hf, good_input_group_b_i = 4'hf;
    logic [NUM_CMP-1:0] cmp_demand_i = 8'h00, manual_trip_i = 8'h00, byp_sw = 8'h00, brk = 8'h00;
    logic [NUM_CMP-1:0] bypass_hold_i, bypass_ind_i, fb_level_i, fb_current_i;
    logic [NUM_CMP-1:0] trip_drive_o, cmp_status_o, fb_fault_o;
    logic               out_of_service_i, failure_alarm_n_o, trouble_alarm_n_o, bypass_alarm_o;
    logic               inoperable_o, rtd_alarm_o, maint_enable_o, oos_alarm_o;
    int                 n_mismatch = 0, checks_done = 0, cyc = 0;
    // short counts keep the persistence and confirm runs brief
    pca_channel_alarm #(.PERSIST_CYCLES(PC), .OOS_CYCLES(OC)) dut (.*);
    pca_field_model u_field (
        .trip_drive_i  (trip_drive_o),
        .break_i       (brk),
        .byp_sw_i      (byp_sw),
        .oos_sw_i      (oos_sw),
        .fb_level_o    (fb_level_i),
        .fb_current_o  (fb_current_i),
        .bypass_hold_o (bypass_hold_i),
        .bypass_ind_o  (bypass_ind_i),
        .oos_contact_o (out_of_service_i),
        .oos_direct_o  ()
    );
    always #20 sys_clk_i = ~sys_clk_i;
    // hang guard
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_mismatch++;
            finish_test();
        end
    end
    // ====================
    // checking tasks
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk_v(input logic [NUM_CMP-1:0] got, input logic [NUM_CMP-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        chk_v({7'h00, got}, {7'h00, exp});
    endtask
    // sample at the falling edge, well clear of the launching edge
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask
    // steady-state model with healthy loads
    task automatic check_all();
        logic [NUM_CMP-1:0] trp;
        logic               byp;
        logic               rtd;
        logic               tro;
        byp = |(byp_sw & (SPRAY_MASK | PERMISSIVE_MASK));
        trp = ((cmp_demand_i | (manual_trip_i & MANUAL_MASK)) & DE_TRIP_MASK)
            | (cmp_demand_i & ~DE_TRIP_MASK & ~(byp_sw & (SPRAY_MASK | PERMISSIVE_MASK)));
        rtd = !delta_avg_temp_channel_oos_i && (deviation_check_group_dev_i
            || $countones(deviation_check_group_bad_i) >= MAX_BAD
            || $countones(good_input_group_a_i) < MIN_GOOD
            || $countones(good_input_group_b_i) < MIN_GOOD);
        tro = minor_fail_i || ^crit_supply_ok_i || !(&noncrit_supply_ok_i);
        chk_v(trip_drive_o, trp ^ DE_TRIP_MASK);
        chk_v(cmp_status_o, trp);
        chk_v(fb_fault_o, 8'h00);
        chk_b(failure_alarm_n_o, !(crit_fail_i || crit_supply_ok_i == 2'h0));
        chk_b(trouble_alarm_n_o, !tro);
        chk_b(bypass_alarm_o, byp);
        chk_b(inoperable_o, byp);
        chk_b(rtd_alarm_o, rtd);
        chk_b(maint_enable_o, oos_sw);
    endtask
    // broken load on one comparator, with or without demand
    task automatic persist(input int b, input logic d, input logic ef, input logic et);
        @(posedge sys_clk_i);
        cmp_demand_i <= d ? NUM_CMP'(1 << b) : 8'h00;
        brk          <= NUM_CMP'(1 << b);
        settle(PC - 2);
        chk_b(failure_alarm_n_o & trouble_alarm_n_o, 1'b1);
        settle(14);
        chk_b(failure_alarm_n_o, !ef);
        chk_b(trouble_alarm_n_o, !et);
        @(posedge sys_clk_i);
        cmp_demand_i <= 8'h00;
        brk          <= 8'h00;
        settle(6);
        chk_b(failure_alarm_n_o & trouble_alarm_n_o, 1'b1);
        $display("test persist bit %0d done", b);
    endtask
    // ====================
    // main sequence
    initial begin
        void'($urandom(32'h292a79e9));
        repeat (2) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(posedge sys_clk_i);
            {cmp_demand_i, manual_trip_i, byp_sw, good_input_group_a_i,
                good_input_group_b_i} <= 32'($urandom());
            {deviation_check_group_bad_i, crit_supply_ok_i, noncrit_supply_ok_i, oos_sw,
                crit_fail_i, minor_fail_i, deviation_check_group_dev_i,
                delta_avg_temp_channel_oos_i} <= 13'($urandom());
            settle(6);
            check_all();
        end
        $display("test random done");
        @(posedge sys_clk_i);
        {cmp_demand_i, manual_trip_i, byp_sw, oos_sw, crit_fail_i, minor_fail_i} <= '0;
        {deviation_check_group_dev_i, delta_avg_temp_channel_oos_i} <= 2'h0;
        {crit_supply_ok_i, noncrit_supply_ok_i} <= 4'hf;
        settle(6);
        check_all();
        persist(0, 1'b1, 1'b1, 1'b0);
        persist(1, 1'b0, 1'b0, 1'b1);
        persist(5, 1'b1, 1'b0, 1'b0);
        persist(2, 1'b1, 1'b0, 1'b0);
        persist(3, 1'b0, 1'b0, 1'b0);
        // energize-to-trip load fault on the spray output
        @(posedge sys_clk_i);
        brk <= 8'h40;
        settle(5);
        chk_v(fb_fault_o, 8'h40);
        chk_b(trouble_alarm_n_o, 1'b0);
        @(posedge sys_clk_i);
        brk    <= 8'h00;
        oos_sw <= 1'b1;
        settle(4);
        chk_b(oos_alarm_o, 1'b0);
        settle(OC + 4);
        chk_b(oos_alarm_o, 1'b1);
        @(posedge sys_clk_i);
        oos_sw <= 1'b0;
        settle(4);
        chk_b(oos_alarm_o, 1'b0);
        $display("test fault and oos done");
        // clock enable low freezes, then a reset in mid-run
        @(posedge sys_clk_i);
        ce_i         <= 1'b0;
        cmp_demand_i <= 8'h01;
        settle(4);
        chk_v(trip_drive_o, DE_TRIP_MASK);
        @(posedge sys_clk_i);
        reset_n_i    <= 1'b0;
        ce_i         <= 1'b1;
        settle(1);
        chk_v(trip_drive_o, DE_TRIP_MASK);
        $display("test freeze and reset done");
        finish_test();
    end
endmodule
bind pca_channel_alarm pca_channel_alarm_checker #(.PERSIST_CYCLES(PERSIST_CYCLES)) u_chk (.*);
`default_nettype wire
